// ---- core/cu_reset_init_sequencer.sv ----
// reset and initialisation sequencer of the control unit
// Notes on behaviour
// [R1] a high pulse on reset starts the full initialisation routine
// [R2] clear registers, mask interrupts, read config, reset units, test, timers, pipeline
// [R3] init code takes 33 microcode words, optional mapper setup 14 more
// [R4] instruction counter and status word zeroed; execution starts at address zero
// [R5] self test is five subroutines in 332 microcode words
// [R6] power-up-good driven low when self test starts
// [R7] power-up-good raised only when all five subroutines pass
// [R8] failure loads subroutine error code into fault register, aborts, good stays low
// [R9] good raise and fault load are commands issued with the unit strobe
// [R10] after failure the reset state may differ from normal
// [R11] a failure code in the fault register sets level 1 pending
// [R12] interrupts stay disabled and masked so failure is not serviced
// [R13] last action loads pipeline from location zero page zero
// [R14] execution begins after pipeline load whether test passed or failed
// [R15] outside logic holds interrupt and fault inputs high during init
// [R16] outside logic clocks timers a and b during init
// [R17] first step enables control of the dma enable output
// [R18] a step clears the execution unit status word
// [R19] mask cleared by command 2000h
// [R20] pending and fault cleared by command 2001h; instruction counter cleared
// [R21] interrupts disabled by command 2003h
// [R22] reset held at least one clock; falling edge starts microcode at zero
// [R23] mapper status word cleared by command 200eh
// [R24] dma access disabled by command 4007h
// [R25] config register read by command 8400h
// [R26] steps for absent units are skipped
//
// Chosen here: the address-and-strobe port and the address map.
`timescale 1ns/1ps
`default_nettype none
module cu_reset_init_sequencer #(
	parameter int SUB_STEPS = 4
) (
	// clock and reset
	input  wire logic                  clk_sys,
	input  wire logic                  rst_n,
	// system reset pin, active high
	input  wire logic                  reset_pin,
	// unit presence
	input  wire logic                  mapper_present,
	input  wire logic                  discrete_present,
	// interrupt, fault and timer clock inputs from pins
	input  wire logic                  interrupt_request_n,
	input  wire logic                  fault_in_n,
	input  wire logic                  timer_clock_ok,
	// self-test subroutine outcomes
	input  wire logic [4:0]            sub_ok,
	// commands to the interrupt unit
	output init_seq_pkg::iu_cmd_s      iu_cmd,
	output logic                       interrupt_unit_strobe,
	// status and discretes
	output logic                       power_up_good_out,
	output logic                       power_up_good_oe_n,
	output logic                       dma_enable_out,
	output logic                       startup_rom_enable,
	output logic                       timers_run,
	output logic                       trigger_go_clear,
	output logic                       level1_pending,
	output logic                       interrupts_enabled,
	output logic [15:0]                interrupt_mask,
	output logic [15:0]                instruction_counter,
	output logic [15:0]                status_word,
	output logic [15:0]                fault_register,
	output logic [15:0]                config_value,
	output logic [11:0]                uaddr,
	output logic                       pipeline_fetch,
	output logic [15:0]                fetch_addr,
	output logic                       run_program,
	output logic                       init_busy
);
	// the stepper counts subroutine steps in eight bits
	if (SUB_STEPS < 1 || SUB_STEPS > 255) begin : g_bad_steps
		$error("cu_reset_init_sequencer: SUB_STEPS out of range");
	end
	// the mapper setup counter is four bits wide
	if (init_seq_pkg::MAPPER_WORDS < 1 || init_seq_pkg::MAPPER_WORDS > 16) begin : g_bad_mapper
		$error("cu_reset_init_sequencer: mapper word count too large");
	end

	typedef enum {
		S_IDLE, S_HOLD, S_DMA_CTRL, S_CLR_SW, S_MASK, S_CLR_PEND, S_INTERRUPT_OFF_COMMAND, S_MAP_SW, S_DMA_OFF,
		S_CFG, S_DISC, S_MAPPER, S_TEST, S_WAIT_TEST, S_REPORT, S_TIMERS, S_PIPE, S_RUN
	} state_e;

	// idle level of the interrupt, fault and timer clock pins, so no false edge follows reset
	localparam logic [1:0]  PIN_IDLE = 2'h3;
	localparam logic [15:0] MASK_ALL = 16'hFFFF;
	localparam init_seq_pkg::iu_cmd_s CMD_IDLE =
		'{valid: 1'b0, code: init_seq_pkg::ZERO_WORD, data: init_seq_pkg::ZERO_WORD};

	state_e     state_q;
	state_e     state_d;
	logic [2:0] rst_sync_q;
	logic [1:0] irq_sync_q;
	logic [1:0] flt_sync_q;
	logic [1:0] tmr_sync_q;
	logic       test_start;
	logic       test_fail_q;
	logic [3:0] map_cnt_q;
	logic [11:0] uaddr_q;
	init_seq_pkg::iu_cmd_s   cmd_d;
	init_seq_pkg::iu_cmd_s   cmd_q;
	init_seq_pkg::test_res_s test_res;

	// pin synchronisers; first stage read only by the second
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			rst_sync_q <= 3'h0;
			irq_sync_q <= PIN_IDLE;
			flt_sync_q <= PIN_IDLE;
			tmr_sync_q <= PIN_IDLE;
		end else begin
			rst_sync_q <= {rst_sync_q[1:0], reset_pin};
			irq_sync_q <= {irq_sync_q[0], interrupt_request_n};
			flt_sync_q <= {flt_sync_q[0], fault_in_n};
			tmr_sync_q <= {tmr_sync_q[0], timer_clock_ok};
		end
	end

	wire reset_hi   = rst_sync_q[1];
	wire reset_fall = rst_sync_q[2] & ~rst_sync_q[1]; // [R22]
	// bad external inputs during init spoil the test rather than stall it
	wire inputs_ok  = irq_sync_q[1] & flt_sync_q[1] & tmr_sync_q[1]; // [R15] [R16]

	function automatic init_seq_pkg::iu_cmd_s mk_cmd(input logic [15:0] code, input logic [15:0] data);
		mk_cmd = '{valid: 1'b1, code: code, data: data};
	endfunction

	// next step once the config read is done; absent units are passed over
	function automatic state_e after_config(input logic disc, input logic map);
		if (disc) begin
			after_config = S_DISC;
		end else if (map) begin
			after_config = S_MAPPER;
		end else begin
			after_config = S_TEST;
		end
	endfunction

	// states that belong to the initialisation routine proper
	function automatic logic in_routine(input state_e s);
		in_routine = (s != S_IDLE) && (s != S_RUN);
	endfunction

	self_test_unit #(
		.SUBS      (init_seq_pkg::SELFTEST_SUBS),
		.SUB_STEPS (SUB_STEPS)
	) u_test (
		.clk_sys (clk_sys),
		.rst_n   (rst_n),
		.start   (test_start),
		.sub_ok  (sub_ok & {5{inputs_ok}}),
		.result  (test_res)
	); // [R5]

	assign test_start = (state_q == S_TEST);

	always_comb begin
		state_d = state_q;
		cmd_d   = CMD_IDLE;
		case (state_q)
			S_IDLE, S_RUN: begin
				if (reset_hi) begin
					state_d = S_HOLD; // [R1]
				end
			end
			S_HOLD: begin
				if (reset_fall) begin
					state_d = S_DMA_CTRL; // [R22]
				end
			end
			S_DMA_CTRL: state_d = S_CLR_SW; // [R17]
			S_CLR_SW:   state_d = S_MASK; // [R18]
			S_MASK: begin
				cmd_d   = mk_cmd(init_seq_pkg::SET_MASK_COMMAND, init_seq_pkg::ZERO_WORD); // [R19]
				state_d = S_CLR_PEND;
			end
			S_CLR_PEND: begin
				cmd_d   = mk_cmd(init_seq_pkg::CLEAR_PENDING_COMMAND, init_seq_pkg::ZERO_WORD); // [R20]
				state_d = S_INTERRUPT_OFF_COMMAND;
			end
			S_INTERRUPT_OFF_COMMAND: begin
				cmd_d   = mk_cmd(init_seq_pkg::INTERRUPT_OFF_COMMAND, init_seq_pkg::ZERO_WORD); // [R21]
				state_d = mapper_present ? S_MAP_SW : S_DMA_OFF; // [R26]
			end
			S_MAP_SW: begin
				cmd_d   = mk_cmd(init_seq_pkg::MAPPER_STATUS_WRITE_COMMAND, init_seq_pkg::ZERO_WORD); // [R23]
				state_d = S_DMA_OFF;
			end
			S_DMA_OFF: begin
				cmd_d   = mk_cmd(init_seq_pkg::DMA_OFF_COMMAND, init_seq_pkg::ZERO_WORD); // [R24]
				state_d = S_CFG;
			end
			S_CFG: begin
				cmd_d   = mk_cmd(init_seq_pkg::CONFIG_READ_COMMAND, init_seq_pkg::ZERO_WORD); // [R25]
				state_d = after_config(discrete_present, mapper_present); // [R26]
			end
			S_DISC: state_d = after_config(1'b0, mapper_present); // [R26]
			S_MAPPER: begin
				if (map_cnt_q == 4'(init_seq_pkg::MAPPER_WORDS - 1)) begin
					state_d = S_TEST; // [R3]
				end
			end
			S_TEST: state_d = S_WAIT_TEST; // [R6]
			S_WAIT_TEST: begin
				if (test_res.done) begin
					state_d = S_REPORT;
				end
			end
			S_REPORT: begin
				if (test_fail_q) begin
					cmd_d = mk_cmd(init_seq_pkg::FAULT_LOAD_COMMAND,
						init_seq_pkg::FAULT_CODE_BASE | {13'h0000, test_res.sub}); // [R8] [R9]
				end else begin
					cmd_d = mk_cmd(init_seq_pkg::POWER_GOOD_COMMAND, init_seq_pkg::ZERO_WORD); // [R7] [R9]
				end
				state_d = S_TIMERS;
			end
			S_TIMERS: state_d = S_PIPE;
			S_PIPE:   state_d = S_RUN; // [R13] [R14]
			default:  state_d = S_IDLE;
		endcase
		if (reset_hi && state_q != S_HOLD) begin
			state_d = S_HOLD; // [R1]
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			state_q <= S_IDLE;
			cmd_q   <= CMD_IDLE;
		end else begin
			state_q <= state_d;
			cmd_q   <= cmd_d;
		end
	end

	// microcode address tracking
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			uaddr_q   <= init_seq_pkg::UADDR_ZERO;
			map_cnt_q <= 4'h0;
		end else if (state_q == S_HOLD) begin
			uaddr_q   <= init_seq_pkg::UADDR_ZERO; // [R22]
			map_cnt_q <= 4'h0;
		end else if (state_q == S_MAPPER) begin
			uaddr_q   <= init_seq_pkg::UADDR_MAPPER + 12'(map_cnt_q); // [R3]
			map_cnt_q <= map_cnt_q + 4'h1;
		end else if (state_q == S_TEST) begin
			uaddr_q <= init_seq_pkg::UADDR_SELFTEST;
		end else if (in_routine(state_q) && state_q != S_WAIT_TEST &&
			uaddr_q < 12'(init_seq_pkg::INIT_WORDS - 1)) begin
			uaddr_q <= uaddr_q + 12'h001;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			test_fail_q <= 1'b0;
		end else if (state_q == S_TEST) begin
			test_fail_q <= 1'b0;
		end else if (state_q == S_WAIT_TEST && test_res.done) begin
			test_fail_q <= test_res.fail;
		end
	end

	// interrupt unit model state set by issued commands; the good flag and its enable are also driven low at test start
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			interrupt_mask     <= MASK_ALL;
			fault_register     <= 16'h0000;
			level1_pending     <= 1'b0;
			interrupts_enabled <= 1'b0;
			power_up_good_out  <= 1'b0;
			power_up_good_oe_n <= 1'b1;
			config_value       <= 16'h0000;
		end else begin
			if (state_q == S_TEST) begin
				power_up_good_out  <= 1'b0; // [R6]
				power_up_good_oe_n <= 1'b0;
			end
			if (cmd_q.valid) begin
				case (cmd_q.code)
					init_seq_pkg::SET_MASK_COMMAND:      interrupt_mask <= init_seq_pkg::ZERO_WORD; // [R12]
					init_seq_pkg::CLEAR_PENDING_COMMAND: begin
						fault_register <= init_seq_pkg::ZERO_WORD;
						level1_pending <= 1'b0;
					end
					init_seq_pkg::INTERRUPT_OFF_COMMAND: interrupts_enabled <= 1'b0; // [R12]
					init_seq_pkg::CONFIG_READ_COMMAND:   config_value <= init_seq_pkg::ZERO_WORD;
					init_seq_pkg::POWER_GOOD_COMMAND:    power_up_good_out <= 1'b1; // [R7]
					init_seq_pkg::FAULT_LOAD_COMMAND: begin
						fault_register <= cmd_q.data; // [R8]
						level1_pending <= 1'b1; // [R11]
					end
					default: ;
				endcase
			end
		end
	end

	// execution unit and discrete side effects
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			dma_enable_out      <= 1'b0;
			status_word         <= 16'h0000;
			instruction_counter <= 16'h0000;
			startup_rom_enable  <= 1'b0;
			timers_run          <= 1'b0;
			trigger_go_clear    <= 1'b0;
			pipeline_fetch      <= 1'b0;
			fetch_addr          <= 16'h0000;
		end else begin
			trigger_go_clear <= 1'b0;
			pipeline_fetch   <= 1'b0;
			case (state_q)
				S_HOLD: begin
					timers_run         <= 1'b0;
					startup_rom_enable <= 1'b0; // [R2]
				end
				S_DMA_CTRL: dma_enable_out <= 1'b1; // [R17]
				S_CLR_SW:   status_word <= init_seq_pkg::ZERO_WORD; // [R18] [R4]
				S_CLR_PEND: instruction_counter <= init_seq_pkg::ZERO_WORD; // [R20] [R4]
				S_DMA_OFF:  dma_enable_out <= 1'b0;
				// failure leaves earlier steps as they are, so the state may differ
				S_REPORT:   startup_rom_enable <= 1'b1; // [R10] [R2]
				S_TIMERS: begin
					timers_run       <= 1'b1; // [R2]
					trigger_go_clear <= 1'b1;
				end
				S_PIPE: begin
					pipeline_fetch <= 1'b1; // [R13]
					fetch_addr     <= instruction_counter; // [R4]
				end
				default: ;
			endcase
		end
	end

	assign iu_cmd                = cmd_q;
	assign interrupt_unit_strobe = cmd_q.valid; // [R9]
	assign uaddr                 = uaddr_q;
	assign run_program           = (state_q == S_RUN); // [R14]
	assign init_busy             = in_routine(state_q);
endmodule : cu_reset_init_sequencer
`default_nettype wire

// ---- core/init_seq_pkg.sv ----
// shared constants and types for the reset and initialisation sequencer
package init_seq_pkg;
	localparam int CMD_W = 16;
	localparam int UADDR_W = 12;
	// internal i/o command codes
	localparam logic [15:0] SET_MASK_COMMAND = 16'h2000;
	localparam logic [15:0] CLEAR_PENDING_COMMAND = 16'h2001;
	localparam logic [15:0] INTERRUPT_OFF_COMMAND = 16'h2003;
	localparam logic [15:0] MAPPER_STATUS_WRITE_COMMAND = 16'h200E;
	localparam logic [15:0] DMA_OFF_COMMAND = 16'h4007;
	localparam logic [15:0] CONFIG_READ_COMMAND = 16'h8400;
	// commands of our own for pass flag and fault load
	localparam logic [15:0] POWER_GOOD_COMMAND = 16'h2010;
	localparam logic [15:0] FAULT_LOAD_COMMAND = 16'h2011;
	// microcode layout
	localparam int INIT_WORDS = 33;
	localparam int MAPPER_WORDS = 14;
	localparam int SELFTEST_WORDS = 332;
	localparam int SELFTEST_SUBS = 5;
	localparam logic [11:0] UADDR_ZERO = 12'h000;
	localparam logic [11:0] UADDR_MAPPER = 12'h021;
	localparam logic [11:0] UADDR_SELFTEST = 12'h02F;
	// fault code: low three bits name the failed subroutine
	localparam logic [15:0] FAULT_CODE_BASE = 16'h0010;
	localparam logic [15:0] ZERO_WORD = 16'h0000;

	typedef struct packed {
		logic        valid;
		logic [15:0] code;
		logic [15:0] data;
	} iu_cmd_s;

	typedef struct packed {
		logic [2:0] sub;
		logic       done;
		logic       fail;
	} test_res_s;
endpackage : init_seq_pkg

// ---- core/self_test_unit.sv ----
// self test stepper: runs the test subroutines in order and reports outcome
`timescale 1ns/1ps
`default_nettype none
module self_test_unit #(
	parameter int SUBS      = 5,
	parameter int SUB_STEPS = 4
) (
	// clock and reset
	input  wire logic                   clk_sys,
	input  wire logic                   rst_n,
	// control
	input  wire logic                   start,
	input  wire logic [SUBS-1:0]        sub_ok,
	// result
	output init_seq_pkg::test_res_s     result
);
	if (SUBS < 1 || SUBS > 7) begin : g_bad_subs
		$error("self_test_unit: SUBS out of range");
	end

	logic [2:0] sub_q;
	logic [7:0] step_q;
	logic       run_q;
	logic       done_q;
	logic       fail_q;

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			sub_q  <= 3'h0;
			step_q <= 8'h00;
			run_q  <= 1'b0;
			done_q <= 1'b0;
			fail_q <= 1'b0;
		end else if (start) begin
			sub_q  <= 3'h0;
			step_q <= 8'h00;
			run_q  <= 1'b1;
			done_q <= 1'b0;
			fail_q <= 1'b0;
		end else if (run_q) begin
			if (step_q == 8'(SUB_STEPS - 1)) begin
				step_q <= 8'h00;
				// abort at the first failing subroutine
				if (!sub_ok[sub_q]) begin
					run_q  <= 1'b0;
					done_q <= 1'b1;
					fail_q <= 1'b1;
				end else if (sub_q == 3'(SUBS - 1)) begin
					run_q  <= 1'b0;
					done_q <= 1'b1;
				end else begin
					sub_q <= sub_q + 3'h1;
				end
			end else begin
				step_q <= step_q + 8'h01;
			end
		end else begin
			done_q <= 1'b0;
		end
	end

	assign result = '{sub: sub_q, done: done_q, fail: fail_q};
endmodule : self_test_unit
`default_nettype wire

// ---- tb/init_seq_monitor.sv ----
// assertions on the sequencer's ports
`timescale 1ns/1ps
`default_nettype none
module init_seq_monitor (
	// clock and reset
	input wire logic                  clk_sys,
	input wire logic                  rst_n,
	// watched ports
	input wire logic                  mapper_present,
	input wire init_seq_pkg::iu_cmd_s iu_cmd,
	input wire logic                  interrupt_unit_strobe,
	input wire logic                  power_up_good_out,
	input wire logic                  power_up_good_oe_n,
	input wire logic                  level1_pending,
	input wire logic                  interrupts_enabled,
	input wire logic [15:0]           interrupt_mask,
	input wire logic [15:0]           fault_register,
	input wire logic [11:0]           uaddr,
	input wire logic                  pipeline_fetch,
	input wire logic [15:0]           fetch_addr,
	input wire logic                  run_program
);
	logic good_cmd_q;
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rst_n);
	sequence cmd_seen(logic [15:0] c);
		interrupt_unit_strobe && iu_cmd.code == c;
	endsequence
	// remembers a pass command so a rise of the good flag can be traced
	always_ff @(posedge clk_sys) begin
		good_cmd_q <= rst_n && interrupt_unit_strobe && iu_cmd.code == init_seq_pkg::POWER_GOOD_COMMAND;
	end
	strobe_valid_a: assert property (interrupt_unit_strobe == iu_cmd.valid)
		else $error("strobe and command valid disagree");
	good_raise_a: assert property (cmd_seen(init_seq_pkg::POWER_GOOD_COMMAND) |=> power_up_good_out)
		else $error("good flag not raised after pass command");
	good_cause_a: assert property ($rose(power_up_good_out) |-> good_cmd_q)
		else $error("good flag rose without pass command");
	fault_load_a: assert property (cmd_seen(init_seq_pkg::FAULT_LOAD_COMMAND)
		|=> fault_register == $past(iu_cmd.data) && level1_pending)
		else $error("fault register or level 1 not set");
	fault_code_a: assert property (cmd_seen(init_seq_pkg::FAULT_LOAD_COMMAND)
		|-> iu_cmd.data[15:3] == init_seq_pkg::FAULT_CODE_BASE[15:3] && iu_cmd.data[2:0] < 3'h5)
		else $error("fault code out of range");
	fail_low_a: assert property (cmd_seen(init_seq_pkg::FAULT_LOAD_COMMAND) |=> !power_up_good_out)
		else $error("good flag high after fault");
	mask_clear_a: assert property (cmd_seen(init_seq_pkg::SET_MASK_COMMAND)
		|-> ##[0:2] interrupt_mask == init_seq_pkg::ZERO_WORD)
		else $error("mask not cleared");
	test_low_a: assert property ($rose(uaddr == init_seq_pkg::UADDR_SELFTEST)
		|-> ##[0:2] (!power_up_good_oe_n && !power_up_good_out))
		else $error("good flag not driven low at test start");
	fetch_zero_a: assert property (pipeline_fetch
		|-> fetch_addr == init_seq_pkg::ZERO_WORD ##[0:4] run_program)
		else $error("fetch not from zero or no run");
	irq_off_a: assert property (run_program |-> !interrupts_enabled)
		else $error("interrupts enabled after init");
	mapper_skip_a: assert property (cmd_seen(init_seq_pkg::MAPPER_STATUS_WRITE_COMMAND) |-> mapper_present)
		else $error("mapper step without mapper");
endmodule // init_seq_monitor
bind cu_reset_init_sequencer init_seq_monitor init_seq_monitor_i (.clk_sys, .rst_n, .mapper_present, .iu_cmd,
	.interrupt_unit_strobe, .power_up_good_out, .power_up_good_oe_n, .level1_pending, .interrupts_enabled,
	.interrupt_mask, .fault_register, .uaddr, .pipeline_fetch, .fetch_addr, .run_program);
`default_nettype wire

// ---- tb/iu_eu_model.sv ----
// model of the execution and interrupt units facing the sequencer
`timescale 1ns/1ps
`default_nettype none
module iu_eu_model (
	// clock
	input  wire logic                  clk_sys,
	// from the sequencer
	input  wire init_seq_pkg::iu_cmd_s iu_cmd,
	input  wire logic                  interrupt_unit_strobe,
	input  wire logic                  level1_pending,
	input  wire logic                  interrupts_enabled,
	// scenario controls
	input  wire logic [2:0]            fail_sub,
	input  wire logic                  fault_hit,
	input  wire logic                  timer_stop,
	// pins back to the sequencer
	output logic                       interrupt_request_n,
	output logic                       fault_in_n,
	output logic                       timer_clock_ok,
	output logic [4:0]                 sub_ok
);
	init_seq_pkg::iu_cmd_s cmds[$];
	// request only while a pending level meets enabled interrupts
	assign interrupt_request_n = !(level1_pending && interrupts_enabled);
	assign fault_in_n = !fault_hit;
	assign timer_clock_ok = !timer_stop;
	// fail_sub of 5 or more means every subroutine passes
	always_comb begin
		sub_ok = 5'h1F;
		if (fail_sub < 3'h5) sub_ok[fail_sub] = 1'b0;
	end
	// commands count only when the strobe qualifies them
	always @(posedge clk_sys) begin
		if (interrupt_unit_strobe === 1'b1) cmds.push_back(iu_cmd);
	end
endmodule // iu_eu_model
`default_nettype wire

// ---- tb/cu_reset_init_sequencer_test.sv ----
// self-checking bench for the reset and initialisation sequencer
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, exp, got) begin cmp_count++; if ((got) !== (exp)) begin n_errors++; \
	$display("MISMATCH %s expected %h seen %h", nm, exp, got); end end
module cu_reset_init_sequencer_test;
	logic clk_sys, rst_n, reset_pin, mapper_present, discrete_present, interrupt_request_n, fault_in_n;
	logic timer_clock_ok, interrupt_unit_strobe, power_up_good_out, power_up_good_oe_n, dma_enable_out;
	logic startup_rom_enable, timers_run, trigger_go_clear, level1_pending, interrupts_enabled;
	logic pipeline_fetch, run_program, init_busy, fault_hit, timer_stop;
	logic [15:0] interrupt_mask, instruction_counter, status_word, fault_register, config_value, fetch_addr;
	logic [11:0] uaddr;
	logic [4:0] sub_ok;
	logic [2:0] fail_sub;
	init_seq_pkg::iu_cmd_s iu_cmd;
	int n_errors, cmp_count, fetches, trigs;
	logic dma_seen;
	cu_reset_init_sequencer #(.SUB_STEPS(2)) cu_reset_init_sequencer_i (.clk_sys, .rst_n, .reset_pin,
		.mapper_present, .discrete_present, .interrupt_request_n, .fault_in_n, .timer_clock_ok, .sub_ok,
		.iu_cmd, .interrupt_unit_strobe, .power_up_good_out, .power_up_good_oe_n, .dma_enable_out,
		.startup_rom_enable, .timers_run, .trigger_go_clear, .level1_pending, .interrupts_enabled,
		.interrupt_mask, .instruction_counter, .status_word, .fault_register, .config_value, .uaddr,
		.pipeline_fetch, .fetch_addr, .run_program, .init_busy);
	iu_eu_model iu_eu_model_i (.clk_sys, .iu_cmd, .interrupt_unit_strobe, .level1_pending,
		.interrupts_enabled, .fail_sub, .fault_hit, .timer_stop, .interrupt_request_n, .fault_in_n,
		.timer_clock_ok, .sub_ok);
	initial begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end
	always @(posedge clk_sys) begin
		if (pipeline_fetch === 1'b1) fetches++;
		if (trigger_go_clear === 1'b1) trigs++;
		if (dma_enable_out === 1'b1) dma_seen = 1'b1;
	end
	task automatic end_sim();
		$display("compares %0d mismatches %0d", cmp_count, n_errors);
		if (n_errors == 0 && cmp_count > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	// pulse the reset pin, then wait bounded for the program to run
	task automatic run_init(input logic map, input logic [2:0] fs, input logic fh, input logic ts);
		int n;
		@(posedge clk_sys);
		mapper_present <= map;
		discrete_present <= map;
		fail_sub <= fs;
		fault_hit <= fh;
		timer_stop <= ts;
		reset_pin <= 1'b1;
		repeat (4) @(posedge clk_sys);
		reset_pin <= 1'b0;
		iu_eu_model_i.cmds.delete();
		fetches = 0;
		trigs = 0;
		dma_seen = 1'b0;
		n = 0;
		@(negedge clk_sys);
		while (run_program !== 1'b1) begin
			n++;
			if (n > 2000) begin
				n_errors++;
				$display("MISMATCH run_program expected 1 seen %b", run_program);
				end_sim();
			end
			@(negedge clk_sys);
		end
		// one more edge so the fetch pulse of the first run cycle is counted
		@(negedge clk_sys);
	endtask
	task automatic check_cmds(input logic [15:0] exp[$]);
		`CHK("cmd count", exp.size(), iu_eu_model_i.cmds.size())
		foreach (exp[i]) if (i < iu_eu_model_i.cmds.size()) `CHK("cmd code", exp[i], iu_eu_model_i.cmds[i].code)
	endtask
	task automatic check_end(input logic good);
		`CHK("good", good, power_up_good_out)
		`CHK("good oe_n", 1'b0, power_up_good_oe_n)
		`CHK("level1", !good, level1_pending)
		`CHK("irq en", 1'b0, interrupts_enabled)
		`CHK("irq req_n", 1'b1, interrupt_request_n)
		`CHK("mask", init_seq_pkg::ZERO_WORD, interrupt_mask)
		`CHK("counter", init_seq_pkg::ZERO_WORD, instruction_counter)
		`CHK("status", init_seq_pkg::ZERO_WORD, status_word)
		`CHK("fetches", 1, fetches)
		`CHK("dma ctrl", 1'b1, dma_seen)
		`CHK("dma en", 1'b0, dma_enable_out)
		`CHK("busy", 1'b0, init_busy)
		`CHK("config", init_seq_pkg::ZERO_WORD, config_value)
		`CHK("uaddr", init_seq_pkg::UADDR_SELFTEST, uaddr)
		if (good) begin
			`CHK("rom en", 1'b1, startup_rom_enable)
			`CHK("timers", 1'b1, timers_run)
			`CHK("trig", 1, trigs)
			`CHK("fault", init_seq_pkg::ZERO_WORD, fault_register)
		end
	endtask
	initial begin
		rst_n = 1'b0;
		reset_pin = 1'b0;
		mapper_present = 1'b0;
		discrete_present = 1'b0;
		fail_sub = 3'h5;
		fault_hit = 1'b0;
		timer_stop = 1'b0;
		repeat (4) @(posedge clk_sys);
		rst_n <= 1'b1;
		run_init(1'b0, 3'h5, 1'b0, 1'b0);
		check_cmds('{16'h2000, 16'h2001, 16'h2003, 16'h4007, 16'h8400, 16'h2010});
		check_end(1'b1);
		$display("test plain_pass done");
		run_init(1'b1, 3'h5, 1'b0, 1'b0);
		check_cmds('{16'h2000, 16'h2001, 16'h2003, 16'h200E, 16'h4007, 16'h8400, 16'h2010});
		check_end(1'b1);
		$display("test mapper_pass done");
		for (int i = 0; i < 5; i++) begin
			run_init(1'b0, 3'(i), 1'b0, 1'b0);
			`CHK("last code", init_seq_pkg::FAULT_LOAD_COMMAND, iu_eu_model_i.cmds[$].code)
			`CHK("fault data", init_seq_pkg::FAULT_CODE_BASE | 16'(i), iu_eu_model_i.cmds[$].data)
			`CHK("fault reg", init_seq_pkg::FAULT_CODE_BASE | 16'(i), fault_register)
			check_end(1'b0);
		end
		$display("test sub_fail done");
		for (int k = 0; k < 2; k++) begin
			run_init(1'b0, 3'h5, k == 0, k == 1);
			`CHK("pin fail good", 1'b0, power_up_good_out)
			`CHK("pin fail code", init_seq_pkg::FAULT_LOAD_COMMAND, iu_eu_model_i.cmds[$].code)
		end
		$display("test pin_fail done");
		@(posedge clk_sys);
		reset_pin <= 1'b1;
		repeat (4) @(posedge clk_sys);
		reset_pin <= 1'b0;
		repeat (9) @(posedge clk_sys);
		run_init(1'b0, 3'h5, 1'b0, 1'b0);
		check_cmds('{16'h2000, 16'h2001, 16'h2003, 16'h4007, 16'h8400, 16'h2010});
		check_end(1'b1);
		$display("test restart done");
		end_sim();
	end
endmodule // cu_reset_init_sequencer_test
`default_nettype wire
